//--- rtci_bus_master.sv
// Behavioural serial bus master that drives the read path's link pins
`default_nettype none
module rtci_bus_master (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Timing
    // Half period above 600 ns so the link sampler sees every phase
    localparam int HALF = 26;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // ==========================================================
    // Conditions and bits
    // Data moves a few cycles after the clock falls, never with it,
    // so the synchronised pins cannot fake a START or STOP
    task automatic cond(input logic first, input logic last);
        tick(4);
        sda_low <= ~first;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= ~last;
        tick(HALF);
        if (!last) begin
            scl <= 1'b0;
        end
    endtask : cond
    task automatic start();
        cond(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        cond(1'b0, 1'b1);
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_low <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_io
    // ==========================================================
    // Bytes
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask : rd_byte
endmodule : rtci_bus_master
`default_nettype wire

//--- rtci_fifo.sv
// Two-entry byte buffer with valid/ready on both sides
`default_nettype none
module rtci_fifo
    import rtci_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    rtci_stream_if.snk in_s,
    rtci_stream_if.src out_s
);
    typedef struct packed {
        logic [RTCI_BUF_DEPTH-1:0][RTCI_BYTE_W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } rtci_fifo_s;

    rtci_fifo_s r;
    rtci_fifo_s n;
    logic push;
    logic pop;

    assign in_s.ready = (r.cnt != 2'h2);
    assign out_s.valid = (r.cnt != 2'h0);
    assign out_s.data = r.mem[r.rp];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_s.data;
            n.wp = ~r.wp;
        end
        if (pop) begin
            n.rp = ~r.rp;
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
        if (rst) begin
            n = '0;
        end
    end

    always_ff @(posedge clk) begin
        r <= n;
    end
endmodule : rtci_fifo
`default_nettype wire

//--- rtci_pkg.sv
// Shared constants and types of the clock-chip serial read path
`default_nettype none
package rtci_pkg;
    // ==========================================================
    // Bus identities and pointer limits
    localparam logic [6:0] RTCI_ID_RTC = 7'h6f;
    localparam logic [6:0] RTCI_ID_SRAM = 7'h57;
    localparam logic [7:0] RTCI_RTC_LAST = 8'h2f;
    localparam logic [7:0] RTCI_SRAM_LAST = 8'h7f;
    localparam logic [7:0] RTCI_PTR_RST = 8'h00;
    localparam logic [7:0] RTCI_IDLE_BYTE = 8'hff;
    // ==========================================================
    // Framing
    localparam int RTCI_BYTE_W = 8;
    localparam int RTCI_BUF_DEPTH = 2;
    localparam logic [3:0] RTCI_LAST_BIT = 4'h7;
    localparam logic [3:0] RTCI_BITS = 4'h8;
    // ==========================================================
    // Link-side protocol states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK_ID = 9'h004,
        ST_WORD = 9'h008,
        ST_ACK_WORD = 9'h010,
        ST_LOAD = 9'h020,
        ST_SEND = 9'h040,
        ST_MACK = 9'h080,
        ST_IGNORE = 9'h100
    } rtci_state_e;
endpackage : rtci_pkg
`default_nettype wire

//--- rtci_read_path.sv
// Serial slave read path: link-side protocol engine and core-side pointer fetch
`default_nettype none
module rtci_read_path
    import rtci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic on_battery,
    output logic mem_req,
    output logic mem_bank,
    output logic [7:0] mem_addr,
    input wire logic mem_valid,
    input wire logic [7:0] mem_data
);
    // ==========================================================
    // State of both domains
    typedef struct packed {
        logic [1:0] rst_s;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] batt_s;
        logic [2:0] ack_s;
        rtci_state_e st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic bank;
        logic rd;
        logic oe;
        logic req_t;
        logic req_fetch;
        logic req_bank;
        logic [7:0] req_byte;
        logic [7:0] rx;
        logic have;
    } rtci_link_s;

    typedef struct packed {
        logic [2:0] req_s;
        logic [7:0] ptr;
        logic bank;
        logic want;
        logic busy;
        logic mbank;
        logic [7:0] addr;
        logic pend;
        logic ack_t;
        logic [7:0] dat;
    } rtci_core_s;

    rtci_link_s lr;
    rtci_link_s ln;
    rtci_core_s cr;
    rtci_core_s cn;

    rtci_stream_if fill_s ();
    rtci_stream_if drain_s ();

    rtci_fifo u_buf (
        .clk(ref_clk),
        .rst(rst),
        .in_s(fill_s.snk),
        .out_s(drain_s.src)
    );

    // ==========================================================
    // Link domain, clocked by link_clk
    logic l_rst, l_scl, l_scl_p, l_sda, l_sda_p, l_batt;
    logic l_rise, l_fall, l_start, l_stop, l_abort, l_got, l_load;
    logic [6:0] l_id;
    logic l_id_ok;

    assign l_rst = lr.rst_s[1];
    assign l_scl = lr.scl_s[1];
    assign l_scl_p = lr.scl_s[2];
    assign l_sda = lr.sda_s[1];
    assign l_sda_p = lr.sda_s[2];
    assign l_batt = lr.batt_s[1];
    assign l_rise = l_scl & ~l_scl_p;
    assign l_fall = ~l_scl & l_scl_p;
    assign l_start = l_scl & l_scl_p & l_sda_p & ~l_sda;
    assign l_stop = l_scl & l_scl_p & ~l_sda_p & l_sda;
    assign l_abort = l_batt | l_start | l_stop;
    assign l_got = lr.ack_s[1] ^ lr.ack_s[2];
    assign l_id = lr.sh[6:0];
    assign l_id_ok = (l_id == RTCI_ID_RTC) || (l_id == RTCI_ID_SRAM);
    assign l_load = l_fall & ((lr.st == ST_LOAD) | ((lr.st == ST_ACK_ID) & lr.oe & lr.rd));

    // Open drain: only the enable moves, the level is always low
    assign sda_out = 1'b0;
    assign sda_oe = lr.oe;

    always_comb begin
        ln = lr;
        ln.rst_s = {lr.rst_s[0], rst};
        ln.scl_s = {lr.scl_s[1:0], scl_in};
        ln.sda_s = {lr.sda_s[1:0], sda_in};
        ln.batt_s = {lr.batt_s[0], on_battery};
        ln.ack_s = {lr.ack_s[1:0], cr.ack_t};
        // Core holds dat steady from its toggle until the next request
        if (l_got) begin
            ln.rx = cr.dat;
            ln.have = 1'b1;
        end
        if (l_rst) begin
            ln.st = ST_IDLE;
            ln.bitcnt = 4'h0;
            ln.sh = 8'h00;
            ln.bank = 1'b0;
            ln.rd = 1'b0;
            ln.oe = 1'b0;
            ln.req_t = 1'b0;
            ln.req_fetch = 1'b0;
            ln.req_bank = 1'b0;
            ln.req_byte = 8'h00;
            ln.rx = 8'h00;
            ln.have = 1'b0;
        end else if (l_abort) begin
            // Battery mode holds the engine idle and the line released
            ln.oe = 1'b0;
            ln.bitcnt = 4'h0;
            ln.st = (l_start & ~l_batt) ? ST_ADDR : ST_IDLE;
        end else begin
            unique case (lr.st)
                ST_IDLE, ST_IGNORE, ST_LOAD: begin
                end
                ST_ADDR: begin
                    if (l_rise) begin
                        ln.sh = {lr.sh[6:0], l_sda};
                        ln.bitcnt = lr.bitcnt + 4'h1;
                        if (lr.bitcnt == RTCI_LAST_BIT) begin
                            ln.bitcnt = 4'h0;
                            if (l_id_ok) begin
                                ln.st = ST_ACK_ID;
                                ln.bank = (l_id == RTCI_ID_SRAM);
                                ln.rd = l_sda;
                                if (l_sda) begin
                                    ln.req_fetch = 1'b1;
                                    ln.req_bank = (l_id == RTCI_ID_SRAM);
                                    ln.req_t = ~lr.req_t;
                                    ln.have = 1'b0;
                                end
                            end else begin
                                ln.st = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ACK_ID, ST_ACK_WORD: begin
                    if (l_fall) begin
                        if (!lr.oe) begin
                            ln.oe = 1'b1;
                        end else begin
                            ln.oe = 1'b0;
                            if (lr.st == ST_ACK_WORD) begin
                                ln.st = ST_IGNORE;
                            end else begin
                                ln.st = lr.rd ? ST_LOAD : ST_WORD;
                            end
                        end
                    end
                end
                ST_WORD: begin
                    if (l_rise) begin
                        ln.sh = {lr.sh[6:0], l_sda};
                        ln.bitcnt = lr.bitcnt + 4'h1;
                        if (lr.bitcnt == RTCI_LAST_BIT) begin
                            ln.bitcnt = 4'h0;
                            ln.st = ST_ACK_WORD;
                            ln.req_fetch = 1'b0;
                            ln.req_byte = {lr.sh[6:0], l_sda};
                            ln.req_bank = lr.bank;
                            ln.req_t = ~lr.req_t;
                        end
                    end
                end
                ST_SEND: begin
                    if (l_fall) begin
                        if (lr.bitcnt == RTCI_BITS) begin
                            ln.oe = 1'b0;
                            ln.st = ST_MACK;
                        end else begin
                            ln.oe = ~lr.sh[6];
                            ln.sh = {lr.sh[6:0], 1'b0};
                            ln.bitcnt = lr.bitcnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (l_rise) begin
                        if (!l_sda) begin
                            ln.st = ST_LOAD;
                            ln.req_fetch = 1'b1;
                            ln.req_bank = lr.bank;
                            ln.req_t = ~lr.req_t;
                            ln.have = 1'b0;
                        end else begin
                            ln.st = ST_IGNORE;
                        end
                    end
                end
            endcase
            // First bit goes out on the fall that ends the acknowledge clock
            if (l_load) begin
                ln.sh = lr.have ? lr.rx : RTCI_IDLE_BYTE;
                ln.oe = lr.have ? ~lr.rx[7] : 1'b0;
                ln.bitcnt = 4'h1;
                ln.st = ST_SEND;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        lr <= ln;
    end

    // ==========================================================
    // Core domain, clocked by ref_clk
    logic c_edge, c_issue;
    logic [7:0] c_last;

    assign c_edge = cr.req_s[1] ^ cr.req_s[2];
    assign c_last = cr.bank ? RTCI_SRAM_LAST : RTCI_RTC_LAST;
    // A fetch waits for buffer room, so memory never returns into a full buffer
    assign c_issue = cr.want & ~cr.busy & fill_s.ready;
    assign fill_s.valid = cr.busy & mem_valid;
    assign fill_s.data = mem_data;
    assign drain_s.ready = ~cr.pend;
    assign mem_req = cr.busy;
    assign mem_bank = cr.mbank;
    assign mem_addr = cr.addr;

    always_comb begin
        cn = cr;
        cn.req_s = {cr.req_s[1:0], lr.req_t};
        if (c_issue) begin
            cn.want = 1'b0;
            cn.busy = 1'b1;
            cn.addr = cr.ptr;
            cn.mbank = cr.bank;
            cn.ptr = (cr.ptr >= c_last) ? RTCI_PTR_RST : cr.ptr + 8'h01;
        end
        if (fill_s.valid) begin
            cn.busy = 1'b0;
        end
        if (drain_s.valid & drain_s.ready) begin
            cn.dat = drain_s.data;
            cn.ack_t = ~cr.ack_t;
            cn.pend = 1'b1;
        end
        // Link fields are steady two edges before the toggle is seen
        if (c_edge) begin
            cn.pend = 1'b0;
            cn.bank = lr.req_bank;
            if (lr.req_fetch) begin
                cn.want = 1'b1;
            end else begin
                cn.ptr = lr.req_byte;
            end
        end
        if (rst) begin
            cn = '0;
            cn.req_s = {cr.req_s[1:0], lr.req_t};
            cn.ptr = RTCI_PTR_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        cr <= cn;
    end

    // ==========================================================
    // Checks
    sequence s_mack_ok;
        (lr.st == ST_MACK) && l_rise && !l_sda && !l_abort;
    endsequence
    sequence s_send_done;
        (lr.st == ST_SEND) && l_fall && (lr.bitcnt == RTCI_BITS) && !l_abort;
    endsequence

    AST_ID_MATCH: assert property (@(posedge link_clk) disable iff (l_rst)
        (lr.st == ST_ACK_ID) |-> (lr.sh[7:1] == RTCI_ID_RTC || lr.sh[7:1] == RTCI_ID_SRAM))
        else $error("acknowledge phase for a foreign identity");
    AST_ACK_DRIVE: assert property (@(posedge link_clk) disable iff (l_rst)
        ((lr.st == ST_ACK_ID || lr.st == ST_ACK_WORD) && l_fall && !lr.oe && !l_abort)
        |=> lr.oe [*1] ##1 (lr.oe || l_fall || l_abort))
        else $error("instruction byte not acknowledged");
    AST_MACK_NEXT: assert property (@(posedge link_clk) disable iff (l_rst)
        s_mack_ok |=> (lr.st == ST_LOAD) && $changed(lr.req_t) && lr.req_fetch)
        else $error("no next byte after master acknowledge");
    AST_NACK_QUIET: assert property (@(posedge link_clk) disable iff (l_rst)
        ((lr.st == ST_MACK) && l_rise && l_sda && !l_abort)
        |=> (lr.st == ST_IGNORE) && !lr.oe)
        else $error("line still driven after master nack");
    AST_BATT_IDLE: assert property (@(posedge link_clk) disable iff (l_rst)
        l_batt |=> (lr.st == ST_IDLE) && !sda_oe)
        else $error("bus answered on battery power");
    AST_MSB_FIRST: assert property (@(posedge link_clk) disable iff (l_rst)
        (l_load && lr.have) |=> (sda_oe == ~lr.sh[7]) && (lr.bitcnt == 4'h1))
        else $error("first bit sent is not the msb");
    AST_RELEASE: assert property (@(posedge link_clk) disable iff (l_rst)
        s_send_done |=> !sda_oe && (lr.st == ST_MACK))
        else $error("line not released after eighth bit");
    AST_PTR_INC: assert property (@(posedge ref_clk) disable iff (rst)
        (c_issue && !c_edge && cr.ptr < c_last) |=> cr.ptr == $past(cr.ptr) + 8'h01)
        else $error("pointer did not advance by one");
    AST_PTR_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
        (c_issue && !c_edge && cr.ptr == RTCI_RTC_LAST && !cr.bank) |=> cr.ptr == RTCI_PTR_RST)
        else $error("pointer did not wrap to zero");
    AST_PTR_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        (c_edge && !lr.req_fetch) |=> cr.ptr == $past(lr.req_byte))
        else $error("pointer not loaded from address byte");
    AST_PTR_RST: assert property (@(posedge ref_clk)
        rst |=> cr.ptr == RTCI_PTR_RST)
        else $error("pointer not cleared by reset");
endmodule : rtci_read_path
`default_nettype wire

//--- rtci_stream_if.sv
// Valid/ready byte stream between the read path and its buffer
`default_nettype none
interface rtci_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rtci_stream_if
`default_nettype wire

//--- tb.sv
// Self-checking bench of the serial read path with a bus master and a memory model
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb
    import rtci_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, link_clk, rst, on_battery, mem_valid;
    logic [7:0] mem_data;
    logic scl, sda_low, sda_out, sda_oe, mem_req, mem_bank;
    logic [7:0] mem_addr;
    wire logic sda_line;
    int seed = 32'h4d6a;
    int mismatches = 0;
    int cmp_count = 0;
    int lat = 2;
    logic [7:0] ptr = 8'h00;
    // ==========================================================
    // Clocks, wire and instances
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Open drain: pulled up unless a party pulls low
    assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);
    rtci_read_path uut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .on_battery(on_battery),
        .mem_req(mem_req), .mem_bank(mem_bank), .mem_addr(mem_addr),
        .mem_valid(mem_valid), .mem_data(mem_data));
    rtci_bus_master m (.clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    // ==========================================================
    // Expectations
    function automatic logic [7:0] exp_byte(input logic b, input logic [7:0] a);
        return a ^ {b, 7'h2c};
    endfunction : exp_byte
    function automatic logic [7:0] nxt(input logic b, input logic [7:0] a);
        logic [7:0] last;
        last = b ? RTCI_SRAM_LAST : RTCI_RTC_LAST;
        return (a >= last) ? RTCI_PTR_RST : a + 8'h01;
    endfunction : nxt
    // ==========================================================
    // Memory model: random latency, garbage data off the strobe
    always @(posedge ref_clk) begin
        if (rst || mem_valid) begin
            mem_valid <= 1'b0;
            mem_data <= 8'($random(seed));
        end else if (mem_req && lat == 0) begin
            mem_valid <= 1'b1;
            mem_data <= exp_byte(mem_bank, mem_addr);
            lat <= 1 + ($random(seed) & 3);
        end else if (mem_req) begin
            lat <= lat - 1;
        end
    end
    // ==========================================================
    // Read sequence; rnd selects a random read over a current-address one
    task automatic rd_seq(input logic [6:0] id, input logic rnd, input logic [7:0] a,
        input int n);
        logic ack;
        logic b;
        logic [7:0] d;
        b = (id == RTCI_ID_SRAM);
        if (rnd) begin
            m.start();
            m.wr_byte({id, 1'b0}, ack);
            `CHK("id_w ack", 1'b1, ack)
            m.wr_byte(a, ack);
            `CHK("addr ack", 1'b1, ack)
            ptr = a;
        end
        m.start();
        m.wr_byte({id, 1'b1}, ack);
        `CHK("id_r ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            m.rd_byte(i < n - 1, d);
            `CHK("data", exp_byte(b, ptr), d)
            ptr = nxt(b, ptr);
        end
        m.rd_byte(1'b0, d);
        `CHK("after nack", 8'hff, d)
        m.stop();
    endtask : rd_seq
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    // ==========================================================
    // Main sequence
    initial begin
        logic ack;
        logic b;
        logic [6:0] bad;
        rst = 1'b1;
        on_battery = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        m.tick(20);
        rd_seq(RTCI_ID_RTC, 1'b0, 8'h00, 2);
        $display("test 1 done");
        rd_seq(RTCI_ID_RTC, 1'b1, 8'h2e, 4);
        rd_seq(RTCI_ID_SRAM, 1'b1, 8'h7e, 3);
        $display("test 2 done");
        for (int i = 0; i < 3; i++) begin
            bad = (i == 0) ? (RTCI_ID_RTC ^ 7'h01) : 7'($random(seed));
            if (bad == RTCI_ID_RTC || bad == RTCI_ID_SRAM) begin
                bad = 7'h00;
            end
            m.start();
            m.wr_byte({bad, 1'b0}, ack);
            `CHK("bad id ack", 1'b0, ack)
            m.stop();
        end
        $display("test 3 done");
        // Address sent on battery must not reach the pointer
        on_battery <= 1'b1;
        m.tick(10);
        m.start();
        m.wr_byte({RTCI_ID_RTC, 1'b0}, ack);
        `CHK("battery ack", 1'b0, ack)
        m.wr_byte(8'h10, ack);
        `CHK("battery addr ack", 1'b0, ack)
        m.stop();
        on_battery <= 1'b0;
        m.tick(10);
        rd_seq(RTCI_ID_RTC, 1'b0, 8'h00, 1);
        $display("test 4 done");
        for (int i = 0; i < 5; i++) begin
            b = 1'($random(seed));
            rd_seq(b ? RTCI_ID_SRAM : RTCI_ID_RTC, 1'($random(seed)),
                8'($unsigned($random(seed)) % (b ? 128 : 48)),
                1 + $unsigned($random(seed)) % 3);
        end
        $display("test 5 done");
        test_done();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        test_done();
    end
endmodule : tb
`default_nettype wire
